// file: pkg/flag_bank_pkg.sv
// Register map, field positions and unmapped read value of the special flag bank
package flag_bank_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	// Word addresses
	localparam logic [ADDR_W-1:0] ADDR_SYS_FLAGS = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_CMD_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CMD_WORD  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_DRV_STAT  = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_VIRT_OUT  = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL      = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR   = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 4'h8;
	// System flag word bit positions
	localparam int SYS_SELF_DIAG   = 0;
	localparam int SYS_ERR_TRACK   = 1;
	localparam int SYS_ERR_STICKY  = 2;
	localparam int SYS_CONST_ONE   = 3;
	localparam int SYS_CONST_ZERO  = 4;
	localparam int SYS_FIRST_SCAN  = 5;
	localparam int SYS_FIRST_SCAN_N = 6;
	localparam int SYS_W           = 7;
	// Control word bits
	localparam int CTRL_SRC_SEL    = 0;
	localparam int CTRL_CLR_STICKY = 1;
	// Widths
	localparam int TERM_W = 12;
	localparam int STAT_W = 9;
	localparam int VOUT_W = 10;
	localparam int IRQ_W  = 3;
	// Interrupt bits
	localparam int IRQ_DIAG  = 0;
	localparam int IRQ_OPERR = 1;
	localparam int IRQ_ALARM = 2;
	localparam logic [DATA_W-1:0] UNMAPPED_VAL = 32'h0;
	typedef enum logic [1:0] {
		SCAN_STOP  = 2'b00,
		SCAN_FIRST = 2'b01,
		SCAN_RUN   = 2'b11
	} scan_state_t;
endpackage

// file: core/scan_refresh.sv
// End-of-scan refresh of terminal commands and drive status
`timescale 1ns/1ps
module scan_refresh
	import flag_bank_pkg::*;
#(
	parameter int TW = TERM_W,
	parameter int SW = STAT_W,
	parameter int VW = VOUT_W
) (
	input  wire logic          clk_in,        // Core clock
	input  wire logic          rst_n_in,      // Sync reset, active low
	input  wire logic          scan_end_in,   // End-of-scan strobe
	input  wire logic          src_sel_in,    // 0 flags, 1 command word
	input  wire logic [TW-1:0] cmd_flags_in,  // Individual command flags
	input  wire logic [TW-1:0] cmd_word_in,   // Command word register
	input  wire logic [SW-1:0] stat_in,       // Synchronised drive status
	input  wire logic [VW-1:0] vout_in,       // Synchronised virtual outputs
	output logic      [TW-1:0] term_out,      // Applied terminal commands
	output logic      [SW-1:0] stat_out,      // Sampled status flags
	output logic      [VW-1:0] vout_out       // Sampled virtual outputs
);
	wire [TW-1:0] term_sel = src_sel_in ? cmd_word_in : cmd_flags_in;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			term_out <= '0;
			stat_out <= '0;
			vout_out <= '0;
		end else if (scan_end_in) begin
			term_out <= term_sel;
			stat_out <= stat_in;
			vout_out <= vout_in;
		end
	end
endmodule // scan_refresh

// file: core/special_flag_bank.sv
// Special flag bank with Avalon-MM register access
`timescale 1ns/1ps
module special_flag_bank
	import flag_bank_pkg::*;
(
	input  wire logic              CORE_CLK_IN,        // 40 MHz core clock
	input  wire logic              RESET_N_IN,         // Sync reset, active low
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS_IN,     // Word address
	input  wire logic              AVS_READ_IN,        // Read strobe
	input  wire logic              AVS_WRITE_IN,       // Write strobe
	input  wire logic [DATA_W-1:0] AVS_WRITEDATA_IN,   // Write data
	input  wire logic [3:0]        AVS_BYTEENABLE_IN,  // Byte enables
	output logic      [DATA_W-1:0] AVS_READDATA_OUT,   // Read data
	output logic                   AVS_WAITREQUEST_OUT, // Wait request
	input  wire logic              RUN_MODE_IN,        // Controller run (1) or stop
	input  wire logic              SCAN_END_IN,        // End-of-scan pulse from sequencer
	input  wire logic              SELF_DIAG_ERR_IN,   // Self-diagnosis error detected
	input  wire logic              OP_ERR_IN,          // Instruction error present
	input  wire logic [STAT_W-1:0] DRIVE_STAT_IN,      // Drive status pins
	input  wire logic [VOUT_W-1:0] VIRT_OUT_IN,        // Output terminal function states
	output logic      [TERM_W-1:0] TERM_CMD_OUT,       // Drive input terminals
	output logic      [SYS_W-1:0]  SYS_FLAGS_OUT,      // System flags to sequencer
	output logic                   IRQ_OUT             // Interrupt, active high
);
	// Pin inputs pass three flops; a change counts once stages two and three agree
	logic [STAT_W-1:0] stat_s1_r, stat_s2_r, stat_s3_r, stat_q_r;
	logic [VOUT_W-1:0] vout_s1_r, vout_s2_r, vout_s3_r, vout_q_r;
	logic [1:0]        err_s1_r, err_s2_r, err_s3_r, err_q_r;

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			stat_s1_r <= '0;
			stat_s2_r <= '0;
			stat_s3_r <= '0;
			vout_s1_r <= '0;
			vout_s2_r <= '0;
			vout_s3_r <= '0;
			err_s1_r  <= '0;
			err_s2_r  <= '0;
			err_s3_r  <= '0;
		end else begin
			stat_s1_r <= DRIVE_STAT_IN;
			stat_s2_r <= stat_s1_r;
			stat_s3_r <= stat_s2_r;
			vout_s1_r <= VIRT_OUT_IN;
			vout_s2_r <= vout_s1_r;
			vout_s3_r <= vout_s2_r;
			err_s1_r  <= {OP_ERR_IN, SELF_DIAG_ERR_IN};
			err_s2_r  <= err_s1_r;
			err_s3_r  <= err_s2_r;
		end
	end

	// Per-bit agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < STAT_W; gi++) begin : g_stat
			always_ff @(posedge CORE_CLK_IN) begin
				if (!RESET_N_IN)
					stat_q_r[gi] <= 1'b0;
				else if (stat_s2_r[gi] == stat_s3_r[gi])
					stat_q_r[gi] <= stat_s3_r[gi];
			end
		end
		for (gi = 0; gi < VOUT_W; gi++) begin : g_vout
			always_ff @(posedge CORE_CLK_IN) begin
				if (!RESET_N_IN)
					vout_q_r[gi] <= 1'b0;
				else if (vout_s2_r[gi] == vout_s3_r[gi])
					vout_q_r[gi] <= vout_s3_r[gi];
			end
		end
		for (gi = 0; gi < 2; gi++) begin : g_err
			always_ff @(posedge CORE_CLK_IN) begin
				if (!RESET_N_IN)
					err_q_r[gi] <= 1'b0;
				else if (err_s2_r[gi] == err_s3_r[gi])
					err_q_r[gi] <= err_s3_r[gi];
			end
		end
	endgenerate

	wire diag_err = err_q_r[0];
	wire op_err   = err_q_r[1];

	// Register decode
	wire wr_en      = AVS_WRITE_IN && AVS_BYTEENABLE_IN[0];
	wire wr_cmdf    = wr_en && (AVS_ADDRESS_IN == ADDR_CMD_FLAGS);
	wire wr_cmdw    = wr_en && (AVS_ADDRESS_IN == ADDR_CMD_WORD);
	wire wr_ctrl    = wr_en && (AVS_ADDRESS_IN == ADDR_CTRL);
	wire wr_irq_clr = wr_en && (AVS_ADDRESS_IN == ADDR_IRQ_CLR);
	wire wr_irq_en  = wr_en && (AVS_ADDRESS_IN == ADDR_IRQ_EN);
	wire clr_sticky = wr_ctrl && AVS_WRITEDATA_IN[CTRL_CLR_STICKY];

	logic [TERM_W-1:0] cmd_flags_r, cmd_word_r;
	logic              src_sel_r;
	logic              diag_r, track_r, sticky_r;
	logic              run_d_r;
	scan_state_t       scan_st_r, scan_st_nxt;
	logic [IRQ_W-1:0]  irq_stat_r, irq_en_r;
	logic [STAT_W-1:0] stat_smp;
	logic [VOUT_W-1:0] vout_smp;
	logic [TERM_W-1:0] term_q;

	// Command flags, command word and source select, written by software
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			cmd_flags_r <= '0;
			cmd_word_r  <= '0;
			src_sel_r   <= 1'b0;
		end else begin
			if (wr_cmdf)
				cmd_flags_r <= AVS_WRITEDATA_IN[TERM_W-1:0];
			if (wr_cmdw)
				cmd_word_r <= AVS_WRITEDATA_IN[TERM_W-1:0];
			if (wr_ctrl)
				src_sel_r <= AVS_WRITEDATA_IN[CTRL_SRC_SEL];
		end
	end

	// Error flags: system-driven; software can only clear the sticky flag
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			diag_r   <= 1'b0;
			track_r  <= 1'b0;
			sticky_r <= 1'b0;
		end else begin
			diag_r  <= diag_err;
			track_r <= op_err;
			// Set wins over a simultaneous clear
			if (op_err)
				sticky_r <= 1'b1;
			else if (clr_sticky)
				sticky_r <= 1'b0;
		end
	end

	// First-scan tracking: a new run starts the first scan, which ends at scan end
	wire run_rise = RUN_MODE_IN && !run_d_r;
	always_comb begin
		scan_st_nxt = scan_st_r;
		case (scan_st_r)
			SCAN_STOP:  if (run_rise) scan_st_nxt = SCAN_FIRST;
			SCAN_FIRST: if (!RUN_MODE_IN) scan_st_nxt = SCAN_STOP;
			            else if (SCAN_END_IN) scan_st_nxt = SCAN_RUN;
			SCAN_RUN:   if (!RUN_MODE_IN) scan_st_nxt = SCAN_STOP;
			default:    scan_st_nxt = SCAN_STOP;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			run_d_r   <= 1'b0;
			scan_st_r <= SCAN_STOP;
		end else begin
			run_d_r   <= RUN_MODE_IN;
			scan_st_r <= scan_st_nxt;
		end
	end

	wire first_scan = (scan_st_r == SCAN_FIRST);

	// System flag word to the sequencer
	always_comb begin
		SYS_FLAGS_OUT                   = '0;
		SYS_FLAGS_OUT[SYS_SELF_DIAG]    = diag_r;
		SYS_FLAGS_OUT[SYS_ERR_TRACK]    = track_r;
		SYS_FLAGS_OUT[SYS_ERR_STICKY]   = sticky_r;
		SYS_FLAGS_OUT[SYS_CONST_ONE]    = 1'b1;
		SYS_FLAGS_OUT[SYS_CONST_ZERO]   = 1'b0;
		SYS_FLAGS_OUT[SYS_FIRST_SCAN]   = first_scan;
		SYS_FLAGS_OUT[SYS_FIRST_SCAN_N] = !first_scan;
	end

	scan_refresh #(
		.TW (TERM_W),
		.SW (STAT_W),
		.VW (VOUT_W)
	) u_refresh (
		.clk_in       (CORE_CLK_IN),
		.rst_n_in     (RESET_N_IN),
		.scan_end_in  (SCAN_END_IN),
		.src_sel_in   (src_sel_r),
		.cmd_flags_in (cmd_flags_r),
		.cmd_word_in  (cmd_word_r),
		.stat_in      (stat_q_r),
		.vout_in      (vout_q_r),
		.term_out     (term_q),
		.stat_out     (stat_smp),
		.vout_out     (vout_smp)
	);
	assign TERM_CMD_OUT = term_q;

	// Interrupts: diag error, operation error, drive alarm (status bit 7)
	wire [IRQ_W-1:0] irq_evt = {stat_smp[STAT_W-2], op_err, diag_err};
	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			irq_stat_r <= '0;
			irq_en_r   <= '0;
		end else begin
			irq_stat_r <= irq_evt | (irq_stat_r & ~(wr_irq_clr ? AVS_WRITEDATA_IN[IRQ_W-1:0] : '0));
			if (wr_irq_en)
				irq_en_r <= AVS_WRITEDATA_IN[IRQ_W-1:0];
		end
	end
	assign IRQ_OUT = |(irq_stat_r & irq_en_r);

	// Read path: one wait cycle, then data registered
	logic rd_done_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		case (AVS_ADDRESS_IN)
			ADDR_SYS_FLAGS: rd_mux = DATA_W'(SYS_FLAGS_OUT);
			ADDR_CMD_FLAGS: rd_mux = DATA_W'(cmd_flags_r);
			ADDR_CMD_WORD:  rd_mux = DATA_W'(cmd_word_r);
			ADDR_DRV_STAT:  rd_mux = DATA_W'(stat_smp);
			ADDR_VIRT_OUT:  rd_mux = DATA_W'(vout_smp);
			ADDR_CTRL:      rd_mux = DATA_W'(src_sel_r);
			ADDR_IRQ_STAT:  rd_mux = DATA_W'(irq_stat_r);
			ADDR_IRQ_EN:    rd_mux = DATA_W'(irq_en_r);
			default:        rd_mux = UNMAPPED_VAL;
		endcase
	end

	always_ff @(posedge CORE_CLK_IN) begin
		if (!RESET_N_IN) begin
			rd_done_r <= 1'b0;
			rdata_r   <= '0;
		end else begin
			rd_done_r <= AVS_READ_IN && !rd_done_r;
			if (AVS_READ_IN && !rd_done_r)
				rdata_r <= rd_mux;
		end
	end
	assign AVS_READDATA_OUT    = rdata_r;
	assign AVS_WAITREQUEST_OUT = AVS_READ_IN && !rd_done_r;

	// Checks
	property p_const_flags;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		SYS_FLAGS_OUT[SYS_CONST_ONE] && !SYS_FLAGS_OUT[SYS_CONST_ZERO];
	endproperty
	a_const_flags: assert property (p_const_flags) else $error("constant flags wrong");

	property p_first_pair;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		SYS_FLAGS_OUT[SYS_FIRST_SCAN] != SYS_FLAGS_OUT[SYS_FIRST_SCAN_N];
	endproperty
	a_first_pair: assert property (p_first_pair) else $error("first-scan pair not inverse");

	// The inverted flag may only drop on the edge after a stop-to-run change
	property p_first_n_fall;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		$fell(SYS_FLAGS_OUT[SYS_FIRST_SCAN_N]) |-> $past(run_rise);
	endproperty
	a_first_n_fall: assert property (p_first_n_fall) else $error("first-scan low without run entry");

	property p_first_start;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		(RUN_MODE_IN && !run_d_r) |=> SYS_FLAGS_OUT[SYS_FIRST_SCAN] || !RUN_MODE_IN;
	endproperty
	a_first_start: assert property (p_first_start) else $error("first scan not started");

	property p_first_end;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		(first_scan && SCAN_END_IN) |=> !SYS_FLAGS_OUT[SYS_FIRST_SCAN];
	endproperty
	a_first_end: assert property (p_first_end) else $error("first scan lasted too long");

	property p_sticky_set;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		op_err |=> sticky_r && track_r;
	endproperty
	a_sticky_set: assert property (p_sticky_set) else $error("error flags not set");

	property p_track_clear;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		!op_err |=> !track_r;
	endproperty
	a_track_clear: assert property (p_track_clear) else $error("tracking flag stuck");

	property p_sticky_hold;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		(sticky_r && !clr_sticky) |=> sticky_r;
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

	property p_diag;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		diag_err |=> SYS_FLAGS_OUT[SYS_SELF_DIAG];
	endproperty
	a_diag: assert property (p_diag) else $error("diag flag not set");

	property p_term_src;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		SCAN_END_IN |=> TERM_CMD_OUT == ($past(src_sel_r) ? $past(cmd_word_r) : $past(cmd_flags_r));
	endproperty
	a_term_src: assert property (p_term_src) else $error("terminal source wrong");

	property p_term_hold;
		@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
		!SCAN_END_IN |=> $stable(TERM_CMD_OUT);
	endproperty
	a_term_hold: assert property (p_term_hold) else $error("terminals changed mid-scan");
endmodule // special_flag_bank

// file: tb/drive_core_model.sv
// Drive control core model: scan strobe, drive status and virtual outputs
`timescale 1ns/1ps
module drive_core_model
	import flag_bank_pkg::*;
(
	input  wire logic              clk_in,       // Core clock
	input  wire logic              rst_n_in,     // Sync reset, active low
	input  wire logic [TERM_W-1:0] term_in,      // Applied terminal commands
	input  wire logic [5:0]        flt_in,       // Status bits 8..3 to show
	input  wire logic [VOUT_W-1:0] vout_in,      // Output functions to show
	output logic                   scan_end_out, // End-of-scan strobe
	output logic      [STAT_W-1:0] stat_out,     // Drive status pins
	output logic      [VOUT_W-1:0] vout_out      // Virtual output terminals
);
	logic [2:0] cnt_r;
	// Eight-cycle scan keeps the run short; a real scan is far longer
	always_ff @(posedge clk_in) begin
		cnt_r        <= rst_n_in ? cnt_r + 3'h1 : 3'h0;
		scan_end_out <= rst_n_in && cnt_r == 3'h7;
		stat_out     <= {flt_in, term_in[1], term_in[0], term_in[0] | term_in[1]};
		vout_out     <= vout_in;
	end
endmodule // drive_core_model

// file: tb/special_flag_bank_tb.sv
// Self-checking bench for the special flag bank
`timescale 1ns/1ps
module special_flag_bank_tb
	import flag_bank_pkg::*;
;
	typedef struct packed {
		logic [TERM_W-1:0] flags;
		logic [TERM_W-1:0] word;
		logic              sel;
		logic [5:0]        flt;
		logic [VOUT_W-1:0] vout;
		logic [TERM_W-1:0] term;
	} row_t;
	row_t rows [4] = '{
		'{12'h555, 12'h0f0, 1'b0, 6'h15, 10'h155, 12'h555},
		'{12'haaa, 12'h0f0, 1'b0, 6'h2a, 10'h2aa, 12'haaa},
		'{12'h555, 12'h801, 1'b1, 6'h3f, 10'h3ff, 12'h801},
		'{12'hfff, 12'h000, 1'b1, 6'h00, 10'h000, 12'h000}
	};
	logic              clk;
	logic              rst_n = 1'b0;
	logic              rd = 1'b0;
	logic              wr = 1'b0;
	logic              run = 1'b0;
	logic              diag = 1'b0;
	logic              operr = 1'b0;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic [3:0]        be = 4'hf;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] d;
	logic              wait_req;
	logic              irq;
	logic              scan_end;
	logic [STAT_W-1:0] stat;
	logic [STAT_W-1:0] es;
	logic [VOUT_W-1:0] vout_pin;
	logic [VOUT_W-1:0] vout = 10'h0;
	logic [5:0]        flt = 6'h0;
	logic [TERM_W-1:0] term;
	logic [TERM_W-1:0] prev = 12'h0;
	logic [SYS_W-1:0]  sys;
	int                errors = 0;
	int                comparisons = 0;

	special_flag_bank i_special_flag_bank (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(be),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req), .RUN_MODE_IN(run), .SCAN_END_IN(scan_end),
		.SELF_DIAG_ERR_IN(diag), .OP_ERR_IN(operr), .DRIVE_STAT_IN(stat), .VIRT_OUT_IN(vout_pin),
		.TERM_CMD_OUT(term), .SYS_FLAGS_OUT(sys), .IRQ_OUT(irq));
	drive_core_model i_drive_core_model (.clk_in(clk), .rst_n_in(rst_n), .term_in(term), .flt_in(flt),
		.vout_in(vout), .scan_end_out(scan_end), .stat_out(stat), .vout_out(vout_pin));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic test_done;
		if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds the request until waitrequest is seen low, then idles one edge
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
		int n;
		n = 0;
		addr  <= a;
		wdata <= wd;
		wr    <= w;
		rd    <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wait_req !== 1'b0 && n < 20);
		if (wait_req !== 1'b0) begin
			errors++;
			test_done;
		end
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
		bus(1'b0, a, 32'h0);
		chk(d & m, e);
	endtask

	task automatic wait_scan;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (scan_end !== 1'b1 && n < 40);
		if (scan_end !== 1'b1) begin
			errors++;
			test_done;
		end
	endtask

	// Checks run right after an edge, so they see what the previous edge left
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'(sys), 32'h48);
		chk(32'(term), 32'h0);
	endtask

	initial begin
		do_reset;
		bus(1'b1, 4'hf, 32'hffffffff);
		rdchk(4'hf, 32'hffffffff, UNMAPPED_VAL);
		rdchk(ADDR_IRQ_CLR, 32'hffffffff, 32'h0);
		rdchk(ADDR_SYS_FLAGS, 32'h7f, 32'h48);
		wait_scan;
		run <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(sys[6:3]), 32'h5);
		wait_scan;
		@(posedge clk);
		chk(32'(sys[6:3]), 32'h9);
		wait_scan;
		@(posedge clk);
		chk(32'(sys[6:3]), 32'h9);
		foreach (rows[i]) begin
			flt  <= rows[i].flt;
			vout <= rows[i].vout;
			wait_scan;
			bus(1'b1, ADDR_CMD_FLAGS, 32'(rows[i].flags));
			bus(1'b1, ADDR_CMD_WORD, 32'(rows[i].word));
			bus(1'b1, ADDR_CTRL, 32'(rows[i].sel));
			chk(32'(term), 32'(prev));
			repeat (3) wait_scan;
			@(posedge clk);
			chk(32'(term), 32'(rows[i].term));
			es = {rows[i].flt, rows[i].term[1], rows[i].term[0], |rows[i].term[1:0]};
			rdchk(ADDR_DRV_STAT, 32'h1ff, 32'(es));
			rdchk(ADDR_VIRT_OUT, 32'h3ff, 32'(rows[i].vout));
			prev = rows[i].term;
		end
		// A write without the low byte lane must leave the command word alone
		be <= 4'he;
		bus(1'b1, ADDR_CMD_WORD, 32'habc);
		be <= 4'hf;
		rdchk(ADDR_CMD_WORD, 32'hfff, 32'(rows[3].word));
		rdchk(ADDR_CMD_FLAGS, 32'hfff, 32'(rows[3].flags));
		rdchk(ADDR_CTRL, 32'h1, 32'(rows[3].sel));
		rdchk(ADDR_IRQ_STAT, 32'h4, 32'h4);
		bus(1'b1, ADDR_IRQ_CLR, 32'h7);
		bus(1'b1, ADDR_IRQ_EN, 32'h2);
		rdchk(ADDR_IRQ_EN, 32'h7, 32'h2);
		operr <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(sys[2:1]), 32'h3);
		chk(32'(irq), 32'h1);
		operr <= 1'b0;
		repeat (8) @(posedge clk);
		chk(32'(sys[2:1]), 32'h2);
		rdchk(ADDR_IRQ_STAT, 32'h2, 32'h2);
		bus(1'b1, ADDR_IRQ_CLR, 32'h2);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h2);
		chk(32'(sys[2]), 32'h0);
		diag <= 1'b1;
		repeat (8) @(posedge clk);
		chk(32'(sys[0]), 32'h1);
		chk(32'(irq), 32'h0);
		bus(1'b1, ADDR_IRQ_EN, 32'h1);
		chk(32'(irq), 32'h1);
		diag <= 1'b0;
		repeat (8) @(posedge clk);
		bus(1'b1, ADDR_IRQ_CLR, 32'h1);
		chk(32'(irq), 32'h0);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(sys[6:3]), 32'h9);
		do_reset;
		test_done;
	end
endmodule // special_flag_bank_tb
